// ### csrrom_pkg.sv
// csrrom_pkg: offsets, field layouts, reset values and enumerations
// for the compare-swap and configuration rom register bank.
// assumes a 32-bit apb register bus with byte addresses.
package csrrom_pkg;

    // register byte offsets
    localparam logic [7:0] OFF_SWAP_DATA = 8'h0c;
    localparam logic [7:0] OFF_SWAP_CMP = 8'h10;
    localparam logic [7:0] OFF_SWAP_CTRL = 8'h14;
    localparam logic [7:0] OFF_ROM_HDR = 8'h18;
    localparam logic [7:0] OFF_BUS_IDENT = 8'h1c;
    localparam logic [7:0] OFF_BUS_OPT = 8'h20;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h40;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h44;
    localparam logic [7:0] OFF_HC_SET = 8'h50;
    localparam logic [7:0] OFF_HC_CLR = 8'h54;

    // swap control fields
    localparam int DONE_BIT = 31;
    localparam int SEL_MSB = 1;
    localparam int RSVD_MSB = 30;
    localparam int RSVD_LSB = 2;

    // host controller control field
    localparam int LINK_ON_BIT = 17;

    // rom header fields
    localparam int INFO_LEN_MSB = 31;
    localparam int INFO_LEN_LSB = 24;
    localparam int CRC_LEN_MSB = 23;
    localparam int CRC_LEN_LSB = 16;
    localparam logic [31:0] ROM_HDR_RESET = 32'h0000_0000;

    // constant bus identification ("1394" in ascii)
    localparam logic [31:0] BUS_IDENT = 32'h3133_3934;

    // bus options: writable bits and reset value
    localparam logic [31:0] BUS_OPT_WMASK = 32'hf8ff_f000;
    localparam logic [31:0] BUS_OPT_RESET = 32'h0000_a002;

    // interrupt status bits
    localparam int IRQ_W = 2;
    localparam int IRQ_DONE = 0;
    localparam int IRQ_FAIL = 1;

    // bus-management resource select codes
    typedef enum logic [1:0] {
        SEL_BUS_MANAGER_ID = 2'h0,
        SEL_BANDWIDTH_AVAILABLE = 2'h1,
        SEL_CHANNELS_AVAILABLE_HI = 2'h2,
        SEL_CHANNELS_AVAILABLE_LO = 2'h3
    } csrrom_sel_e;

    // compare-swap engine states, one-hot
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_BUSY = 2'b10
    } csrrom_state_e;

    // bus-management resources as seen by the link
    typedef struct packed {
        logic [31:0] bus_manager_id;
        logic [31:0] bandwidth_available;
        logic [31:0] channels_available_hi;
        logic [31:0] channels_available_lo;
    } csrrom_res_s;

    // configuration rom quadlets handed to the link
    typedef struct packed {
        logic [31:0] rom_header;
        logic [31:0] bus_ident;
        logic [31:0] bus_options;
    } csrrom_rom_s;

endpackage

// ### csrrom_regs.sv
// csrrom_regs: apb register bank for compare-swap on the four
// bus-management resources plus the first configuration rom quadlets.
// assumes an apb master on clk and an asynchronous active-high reset.
//
// Summary of operation
// [R1] compare register holds value checked against the resource; no reset
// [R2] swap data enters the resource only when the compare matches
// [R3] control register governs the operation and holds the resource select
// [R4] done flag in control bit 31 sets when a compare-swap finishes
// [R5] a write to the control register clears the done flag unless a compare-swap finishes in that cycle
// [R6] control bits 30 to 2 read zero and ignore writes
// [R7] select 00 manager id, 01 bandwidth, 10 channels hi, 11 channels lo
// [R8] control write starts one compare-swap; done stays low until it ends
// [R9] rom header register is the first configuration rom quadlet
// [R10] header info length 31:24, crc length 23:16, read/write, reset zero
// [R11] software keeps header values valid while link enable is set
// [R12] link enable is host control bit 17, set at 50h, cleared at 54h
// [R13] bus identification reads constant 31333934h, read only
// [R14] bus options is the second bus info quadlet, mixed access
`timescale 1ns/10ps
`default_nettype none

module csrrom_regs #(
    parameter int SWAP_CYCLES = 4,
    parameter logic [31:0] RES_INIT = 32'h0000_0000
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    output logic link_on_control,
    output csrrom_pkg::csrrom_res_s resources,
    output csrrom_pkg::csrrom_rom_s rom_quadlets
);

    localparam int CNT_W = $clog2(SWAP_CYCLES + 1);
    localparam int SWAP_BOUND = SWAP_CYCLES + 1;

    csrrom_pkg::csrrom_state_e state_q;
    logic [CNT_W-1:0] cnt_q;
    logic [31:0] swap_data_q;
    logic [31:0] swap_cmp_q;
    logic [1:0] resource_select_q;
    logic swap_complete_flag_q;
    logic [3:0][31:0] res_q;
    logic [31:0] rom_hdr_q;
    logic [31:0] bus_opt_q;
    logic [csrrom_pkg::IRQ_W-1:0] irq_stat_q;
    logic [csrrom_pkg::IRQ_W-1:0] irq_stat_d;
    logic [csrrom_pkg::IRQ_W-1:0] irq_mask_q;
    logic link_on_q;
    logic [31:0] prdata_q;
    logic slverr_q;
    logic [31:0] rd_mux;
    logic rd_ok;
    logic setup;
    logic wr_en;
    logic wr_ctrl;
    logic start_op;
    logic finish;
    logic match;
    logic [31:0] ctrl_word;

    ////////////////////////////////////////////////////////////////////
    // apb handshake: zero wait states in the access phase

    assign setup = psel & ~penable;
    assign pready = psel & penable;
    assign wr_en = psel & penable & pwrite & rd_ok;
    assign wr_ctrl = wr_en & (paddr == csrrom_pkg::OFF_SWAP_CTRL);
    assign pslverr = psel & penable & slverr_q;
    assign prdata = prdata_q;

    // control word as read back; reserved bits forced to zero
    always_comb begin
        ctrl_word = '0; // see [R6]
        ctrl_word[csrrom_pkg::DONE_BIT] = swap_complete_flag_q;
        ctrl_word[csrrom_pkg::SEL_MSB:0] = resource_select_q;
    end

    // read mux and address decode
    always_comb begin
        rd_mux = '0;
        rd_ok = 1'b1;
        case (paddr)
            csrrom_pkg::OFF_SWAP_DATA: rd_mux = swap_data_q;
            csrrom_pkg::OFF_SWAP_CMP: rd_mux = swap_cmp_q;
            csrrom_pkg::OFF_SWAP_CTRL: rd_mux = ctrl_word;
            csrrom_pkg::OFF_ROM_HDR: rd_mux = rom_hdr_q; // see [R9]
            csrrom_pkg::OFF_BUS_IDENT: rd_mux = csrrom_pkg::BUS_IDENT;
            csrrom_pkg::OFF_BUS_OPT: rd_mux = bus_opt_q; // see [R14]
            csrrom_pkg::OFF_IRQ_STAT: rd_mux[csrrom_pkg::IRQ_W-1:0] = irq_stat_q;
            csrrom_pkg::OFF_IRQ_MASK: rd_mux[csrrom_pkg::IRQ_W-1:0] = irq_mask_q;
            csrrom_pkg::OFF_HC_SET,
            csrrom_pkg::OFF_HC_CLR: begin
                rd_mux[csrrom_pkg::LINK_ON_BIT] = link_on_q;
            end
            default: rd_ok = 1'b0;
        endcase
    end

    // read data and error are captured in the setup cycle
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            prdata_q <= '0;
            slverr_q <= 1'b0;
        end else if (setup) begin
            prdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
            slverr_q <= ~rd_ok;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // swap operands: data and compare, no reset, host writes ignored while busy

    always_ff @(posedge clk) begin
        if (finish) begin
            swap_data_q <= res_q[resource_select_q]; // old value returned
        end else if (wr_en && paddr == csrrom_pkg::OFF_SWAP_DATA &&
                     state_q == csrrom_pkg::ST_IDLE) begin
            swap_data_q <= pwdata;
        end
    end

    // compare value written by the host
    always_ff @(posedge clk) begin
        if (wr_en && paddr == csrrom_pkg::OFF_SWAP_CMP &&
            state_q == csrrom_pkg::ST_IDLE) begin
            swap_cmp_q <= pwdata; // see [R1]
        end
    end

    ////////////////////////////////////////////////////////////////////
    // swap control: select field and done flag

    assign start_op = wr_ctrl & (state_q == csrrom_pkg::ST_IDLE); // see [R8]

    // select only changes when a new operation is launched
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            resource_select_q <= csrrom_pkg::SEL_BUS_MANAGER_ID;
        end else if (start_op) begin
            resource_select_q <= pwdata[csrrom_pkg::SEL_MSB:0]; // see [R3]
        end
    end

    // done flag: completion wins over a clearing write in the same cycle
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            swap_complete_flag_q <= 1'b1;
        end else if (finish) begin
            swap_complete_flag_q <= 1'b1; // see [R4]
        end else if (wr_ctrl) begin
            swap_complete_flag_q <= 1'b0; // see [R5]
        end
    end

    ////////////////////////////////////////////////////////////////////
    // compare-swap engine

    assign finish = (state_q == csrrom_pkg::ST_BUSY) && (cnt_q == '0);
    assign match = (res_q[resource_select_q] == swap_cmp_q);

    // busy for a fixed number of cycles, the last of which is the finish cycle
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_q <= csrrom_pkg::ST_IDLE;
            cnt_q <= '0;
        end else begin
            unique case (state_q)
                csrrom_pkg::ST_IDLE: begin
                    if (start_op) begin
                        state_q <= csrrom_pkg::ST_BUSY;
                        cnt_q <= CNT_W'(SWAP_CYCLES - 1);
                    end
                end
                csrrom_pkg::ST_BUSY: begin
                    if (cnt_q == '0) begin
                        state_q <= csrrom_pkg::ST_IDLE;
                    end else begin
                        cnt_q <= cnt_q - 1'b1;
                    end
                end
                default: begin
                    state_q <= csrrom_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // resources: swapped only on a matching compare
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            res_q <= {4{RES_INIT}};
        end else if (finish && match) begin
            res_q[resource_select_q] <= swap_data_q; // see [R2] [R7]
        end
    end

    assign resources.bus_manager_id =
        res_q[csrrom_pkg::SEL_BUS_MANAGER_ID];
    assign resources.bandwidth_available =
        res_q[csrrom_pkg::SEL_BANDWIDTH_AVAILABLE];
    assign resources.channels_available_hi =
        res_q[csrrom_pkg::SEL_CHANNELS_AVAILABLE_HI];
    assign resources.channels_available_lo =
        res_q[csrrom_pkg::SEL_CHANNELS_AVAILABLE_LO];

    ////////////////////////////////////////////////////////////////////
    // configuration rom quadlets and link enable

    // header is fully writable; software keeps it valid while linked
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rom_hdr_q <= csrrom_pkg::ROM_HDR_RESET; // see [R10]
        end else if (wr_en && paddr == csrrom_pkg::OFF_ROM_HDR) begin
            rom_hdr_q <= pwdata; // see [R10] [R11]
        end
    end

    // bus options: only the writable fields take the written value
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            bus_opt_q <= csrrom_pkg::BUS_OPT_RESET;
        end else if (wr_en && paddr == csrrom_pkg::OFF_BUS_OPT) begin // see [R14]
            bus_opt_q <= (pwdata & csrrom_pkg::BUS_OPT_WMASK) |
                         (bus_opt_q & ~csrrom_pkg::BUS_OPT_WMASK);
        end
    end

    // link enable through a set / clear pair of addresses
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            link_on_q <= 1'b0;
        end else if (wr_en && paddr == csrrom_pkg::OFF_HC_SET &&
                     pwdata[csrrom_pkg::LINK_ON_BIT]) begin
            link_on_q <= 1'b1; // see [R12]
        end else if (wr_en && paddr == csrrom_pkg::OFF_HC_CLR &&
                     pwdata[csrrom_pkg::LINK_ON_BIT]) begin
            link_on_q <= 1'b0;
        end
    end

    assign link_on_control = link_on_q;
    assign rom_quadlets.rom_header = rom_hdr_q;
    assign rom_quadlets.bus_ident = csrrom_pkg::BUS_IDENT; // see [R13]
    assign rom_quadlets.bus_options = bus_opt_q;

    ////////////////////////////////////////////////////////////////////
    // interrupts: sticky status, write one to clear, set wins

    always_comb begin
        irq_stat_d = irq_stat_q;
        if (wr_en && paddr == csrrom_pkg::OFF_IRQ_STAT) begin
            irq_stat_d = irq_stat_q & ~pwdata[csrrom_pkg::IRQ_W-1:0];
        end
        if (finish) begin
            irq_stat_d[csrrom_pkg::IRQ_DONE] = 1'b1;
            irq_stat_d[csrrom_pkg::IRQ_FAIL] =
                irq_stat_d[csrrom_pkg::IRQ_FAIL] | ~match;
        end
    end

    // status and mask registers
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            irq_stat_q <= '0;
            irq_mask_q <= '0;
        end else begin
            irq_stat_q <= irq_stat_d;
            if (wr_en && paddr == csrrom_pkg::OFF_IRQ_MASK) begin
                irq_mask_q <= pwdata[csrrom_pkg::IRQ_W-1:0];
            end
        end
    end

    assign irq = |(irq_stat_q & irq_mask_q);

    ////////////////////////////////////////////////////////////////////
    // assertions and covers

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    cmp_store_a: assert property ( // see [R1]
        (wr_en && paddr == csrrom_pkg::OFF_SWAP_CMP &&
         state_q == csrrom_pkg::ST_IDLE) |=> swap_cmp_q == $past(pwdata))
        else $error("compare register did not take written value");

    swap_match_a: assert property ( // see [R2]
        (finish && match) |=>
            res_q[$past(resource_select_q)] == $past(swap_data_q))
        else $error("matching compare did not swap the resource");

    swap_keep_a: assert property ( // see [R2]
        (finish && !match) |=> res_q == $past(res_q))
        else $error("resource changed on a failed compare");

    sel_capture_a: assert property ( // see [R3] [R7]
        start_op |=>
            resource_select_q == $past(pwdata[csrrom_pkg::SEL_MSB:0]))
        else $error("select field not captured at start");

    done_set_a: assert property ( // see [R4]
        start_op |-> ##[1:SWAP_BOUND] $rose(swap_complete_flag_q))
        else $error("done flag not set after compare-swap");

    done_clear_a: assert property ( // see [R5]
        (wr_ctrl && !finish) |=> !swap_complete_flag_q)
        else $error("control write did not clear done flag");

    ctrl_rsvd_a: assert property ( // see [R6]
        (setup && !pwrite && paddr == csrrom_pkg::OFF_SWAP_CTRL) |=>
            prdata_q[csrrom_pkg::RSVD_MSB:csrrom_pkg::RSVD_LSB] == '0)
        else $error("reserved control bits read nonzero");

    busy_low_a: assert property ( // see [R8]
        start_op |=> (!swap_complete_flag_q &&
                      state_q == csrrom_pkg::ST_BUSY) [*2])
        else $error("done flag high during operation");

    hdr_write_a: assert property ( // see [R9] [R10]
        (wr_en && paddr == csrrom_pkg::OFF_ROM_HDR) |=>
            rom_quadlets.rom_header == $past(pwdata))
        else $error("rom header write lost");

    link_set_a: assert property ( // see [R12]
        (wr_en && paddr == csrrom_pkg::OFF_HC_SET &&
         pwdata[csrrom_pkg::LINK_ON_BIT]) |=> link_on_control)
        else $error("link enable not set");

    ident_read_a: assert property ( // see [R13]
        (setup && !pwrite && paddr == csrrom_pkg::OFF_BUS_IDENT) |=>
            prdata == 32'h3133_3934)
        else $error("bus identification read wrong");

    swap_ok_c: cover property (start_op ##[1:SWAP_BOUND] (finish && match));
    swap_fail_c: cover property (finish && !match);
    irq_seen_c: cover property ($rose(irq));
    link_on_c: cover property ($rose(link_on_control));

endmodule

`default_nettype wire

// ### csrrom_regs_tb.sv
// csrrom_regs_tb: self-checking bench for the compare-swap register bank.
// assumes csrrom_pkg is compiled first; the bench acts as the apb master.
`timescale 1ns/10ps
`default_nettype none

module csrrom_regs_tb;
    localparam logic [31:0] INIT = 32'h1234_5678;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic link_on_control;
    csrrom_pkg::csrrom_res_s resources;
    csrrom_pkg::csrrom_rom_s rom_quadlets;
    int bad_count = 0;
    int cmp_count = 0;
    int cycles = 0;
    logic [31:0] rv;
    logic err;
    logic [31:0] exp_res [4];

    csrrom_regs #(.SWAP_CYCLES(6), .RES_INIT(INIT)) u_dut (
        .clk(clk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq),
        .link_on_control(link_on_control), .resources(resources),
        .rom_quadlets(rom_quadlets)
    );

    // 8 ns clock
    always #4 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////
    // verdict and hang guard
    task automatic end_sim;
        if (bad_count == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // cycle ceiling well above the expected run length
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            bad_count = bad_count + 1;
            end_sim();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count = cmp_count + 1;
        if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // apb transfer: setup, then access held until pready is sampled high;
    // entered right after a rising edge, returns one idle edge later so
    // outputs launched by the access edge have settled
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        rv = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0);
    endtask

    // poll the control register until the done flag shows; the cycle
    // ceiling ends a hang
    task automatic wait_done;
        rd(csrrom_pkg::OFF_SWAP_CTRL);
        while (rv[31] !== 1'b1) begin
            rd(csrrom_pkg::OFF_SWAP_CTRL);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_reset_values;
        rd(csrrom_pkg::OFF_SWAP_CTRL);
        chk(rv & 32'hffff_fffc, 32'h8000_0000);
        rd(csrrom_pkg::OFF_ROM_HDR);
        chk(rv, 32'h0);
        rd(csrrom_pkg::OFF_BUS_IDENT);
        chk(rv, 32'h3133_3934);
        rd(csrrom_pkg::OFF_BUS_OPT);
        chk(rv, 32'h0000_a002);
        chk({30'h0, irq, link_on_control}, 32'h0);
    endtask

    task automatic t_rom_regs;
        wr(csrrom_pkg::OFF_ROM_HDR, 32'h0415_beef);
        rd(csrrom_pkg::OFF_ROM_HDR);
        chk(rv, 32'h0415_beef);
        chk(rom_quadlets.rom_header, 32'h0415_beef);
        wr(csrrom_pkg::OFF_BUS_IDENT, 32'h0);
        rd(csrrom_pkg::OFF_BUS_IDENT);
        chk(rv, 32'h3133_3934);
        chk(rom_quadlets.bus_ident, 32'h3133_3934);
        // writable fields take ones, read-only fields keep their defaults
        wr(csrrom_pkg::OFF_BUS_OPT, 32'hffff_ffff);
        rd(csrrom_pkg::OFF_BUS_OPT);
        chk(rv, 32'hf8ff_f002);
        chk(rom_quadlets.bus_options, 32'hf8ff_f002);
    endtask

    // one compare-swap; a wrong compare value must leave the resource alone
    task automatic t_swap(input logic [1:0] s, input logic [31:0] nv,
                          input logic hit);
        logic [31:0] old;
        logic [127:0] r;
        old = exp_res[s];
        wr(csrrom_pkg::OFF_SWAP_DATA, nv);
        wr(csrrom_pkg::OFF_SWAP_CMP, hit ? old : ~old);
        rd(csrrom_pkg::OFF_SWAP_CMP);
        chk(rv, hit ? old : ~old);
        wr(csrrom_pkg::OFF_SWAP_CTRL, 32'h7fff_fffc | {30'h0, s});
        rd(csrrom_pkg::OFF_SWAP_CTRL);
        chk(rv, {30'h0, s});
        wait_done();
        chk(rv, 32'h8000_0000 | {30'h0, s});
        if (hit) begin
            exp_res[s] = nv;
        end
        r = resources;
        chk(r[(3 - s) * 32 +: 32], exp_res[s]);
        rd(csrrom_pkg::OFF_SWAP_DATA);
        chk(rv, old);
    endtask

    task automatic t_irq;
        rd(csrrom_pkg::OFF_IRQ_STAT);
        chk(rv, 32'h3);
        chk({31'h0, irq}, 32'h0);
        wr(csrrom_pkg::OFF_IRQ_MASK, 32'h2);
        chk({31'h0, irq}, 32'h1);
        wr(csrrom_pkg::OFF_IRQ_STAT, 32'h2);
        chk({31'h0, irq}, 32'h0);
        rd(csrrom_pkg::OFF_IRQ_STAT);
        chk(rv, 32'h1);
        wr(csrrom_pkg::OFF_IRQ_MASK, 32'h1);
        chk({31'h0, irq}, 32'h1);
        wr(csrrom_pkg::OFF_IRQ_STAT, 32'h1);
        chk({31'h0, irq}, 32'h0);
    endtask

    task automatic t_link_and_decode;
        // header was loaded with valid values before the link is enabled
        wr(csrrom_pkg::OFF_HC_SET, 32'h0002_0000);
        chk({31'h0, link_on_control}, 32'h1);
        rd(csrrom_pkg::OFF_HC_SET);
        chk(rv & 32'h0002_0000, 32'h0002_0000);
        wr(csrrom_pkg::OFF_HC_CLR, 32'h0002_0000);
        chk({31'h0, link_on_control}, 32'h0);
        rd(8'h3c);
        chk({31'h0, err}, 32'h1);
        chk(rv, 32'h0);
        rd(csrrom_pkg::OFF_BUS_IDENT);
        chk({31'h0, err}, 32'h0);
    endtask

    // reset in mid-run returns link, header and control to defaults
    task automatic t_mid_reset;
        wr(csrrom_pkg::OFF_HC_SET, 32'h0002_0000);
        chk({31'h0, link_on_control}, 32'h1);
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        chk({31'h0, link_on_control}, 32'h0);
        rd(csrrom_pkg::OFF_ROM_HDR);
        chk(rv, 32'h0);
        rd(csrrom_pkg::OFF_SWAP_CTRL);
        chk(rv, 32'h8000_0000);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        for (int i = 0; i < 4; i++) begin
            exp_res[i] = INIT;
        end
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        t_reset_values();
        t_rom_regs();
        for (int i = 0; i < 4; i++) begin
            t_swap(i[1:0], 32'ha0a0_0000 | i, 1'b1);
        end
        t_swap(2'h2, 32'h5555_aaaa, 1'b0);
        t_irq();
        t_link_and_decode();
        t_mid_reset();
        end_sim();
    end
endmodule

`default_nettype wire
